// ==== hw/ext_int_ctrl.sv ====
// Purpose: external interrupt control: NMI level readback, NMI edge choice,
//          IRQ line sense selection, NMI request pulses, line request pulses or levels and an event interrupt
// Assumes: one 10 MHz clock; pins are asynchronous and synchronised here
// Notes:   IRQ pins are active low; line k maps to lines 0,1,2,3,6,7
//
// How it works
// - Control bit 15 reads the present synchronised level of the NMI pin.
// - Bus writes never change bit 15; it only follows the pin.
// - Control bits 14 to 9, 3 and 2 always read as zero.
// - With the edge bit (8) at 0, the reset value, a falling NMI edge requests.
// - With the edge bit at 1, a rising NMI edge requests instead.
// - A line sense bit at 0 requests while the line is low, at 1 on a fall.
`timescale 1ns/1ps
`default_nettype none
module ext_int_ctrl
	import eic_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [STRB_W-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// interrupt pins
	input wire logic nmi_pin,
	input wire logic [LINES-1:0] irq_pin_b,
	// requests towards the arbiter and the cpu
	output logic nmi_req,
	output logic [LINES-1:0] irq_req,
	output logic irq_out
);

	typedef struct packed {
		edge_pol_t nmi_edge_polarity;
		logic [LINES-1:0] sense;
		logic [REG_W-1:0] status;
		logic [REG_W-1:0] mask;
		logic nmi_req;
		logic [LINES-1:0] irq_req;
		logic irq_out;
	} ctrl_state_t;

	ctrl_state_t st_ff;
	ctrl_state_t nxt_st;

	wr_req_t wr_req;
	logic wr_fire;
	logic wr_err;
	logic [ADDR_W-1:0] rd_addr;
	logic rd_fire;
	logic [DATA_W-1:0] rd_data;
	logic rd_err;

	logic nmi_level;
	logic nmi_rose;
	logic nmi_fell;
	logic [LINES-1:0] irq_level;
	logic [LINES-1:0] irq_fell;

	logic [REG_W-1:0] ctrl_img;
	logic [REG_W-1:0] events;
	logic [REG_W-1:0] rd_clear;
	logic [REG_W-1:0] lane_mask;
	logic [REG_W-1:0] merged;
	logic [LINES-1:0] line_evt;
	logic nmi_evt;

	// protection bits carry no meaning for these registers
	logic prot_unused;
	assign prot_unused = ^{awprot, arprot};

	// bus front end
	axil_port u_port (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_req(wr_req),
		.wr_fire(wr_fire),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_fire(rd_fire),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// pins cross into the clock domain before any detection
	pin_sync u_nmi_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin(nmi_pin),
		.level(nmi_level),
		.rose(nmi_rose),
		.fell(nmi_fell)
	);

	for (genvar k = 0; k < LINES; k++)
	begin : g_line
		pin_sync u_line_sync (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.pin(irq_pin_b[k]),
			.level(irq_level[k]),
			.rose(),
			.fell(irq_fell[k])
		);
	end

	// control image; unlisted bits stay zero
	always_comb
	begin
		ctrl_img = '0;
		ctrl_img[NMI_LEVEL_POS] = nmi_level;
		ctrl_img[NMI_EDGE_POS] = st_ff.nmi_edge_polarity;
		for (int k = 0; k < LINES; k++)
			ctrl_img[SENSE_POS[k]] = st_ff.sense[k];
	end

	// read decode; unmapped words answer SLVERR with zero data
	always_comb
	begin
		rd_data = '0;
		rd_err = 1'h0;
		unique case ({rd_addr[ADDR_W-1:2], 2'h0})
			CTRL_OFS: rd_data[REG_W-1:0] = ctrl_img;
			STAT_OFS: rd_data[REG_W-1:0] = st_ff.status;
			MASK_OFS: rd_data[REG_W-1:0] = st_ff.mask;
			default: rd_err = 1'h1;
		endcase
	end

	// write decode is checked before the write is committed
	always_comb
	begin
		unique case ({wr_req.addr[ADDR_W-1:2], 2'h0})
			CTRL_OFS, STAT_OFS, MASK_OFS: wr_err = 1'h0;
			default: wr_err = 1'h1;
		endcase
	end

	// detection, events and register updates
	always_comb
	begin
		nxt_st = st_ff;
		// the edge bit picks which transition counts
		if (st_ff.nmi_edge_polarity == EDGE_RISING)
			nmi_evt = nmi_rose;
		else
			nmi_evt = nmi_fell;
		// level mode repeats every cycle the line is low
		for (int k = 0; k < LINES; k++)
		begin
			if (sense_t'(st_ff.sense[k]) == SENSE_FALL_EDGE)
				line_evt[k] = irq_fell[k];
			else
				line_evt[k] = ~irq_level[k];
		end
		nxt_st.nmi_req = nmi_evt;
		nxt_st.irq_req = line_evt;
		// events share the control layout in the status register
		events = '0;
		events[NMI_STAT_POS] = nmi_evt;
		for (int k = 0; k < LINES; k++)
			events[SENSE_POS[k]] = line_evt[k];
		// a status read clears, but an event in the same cycle survives
		rd_clear = '0;
		if (rd_fire && {rd_addr[ADDR_W-1:2], 2'h0} == STAT_OFS)
			rd_clear = STAT_MASK;
		nxt_st.status = ((st_ff.status & ~rd_clear) | events) & STAT_MASK;
		// byte lanes 0 and 1 cover the 16-bit registers
		lane_mask = {{8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};
		merged = '0;
		if (wr_fire)
		begin
			unique case ({wr_req.addr[ADDR_W-1:2], 2'h0})
				CTRL_OFS:
				begin
					// level and unused bits are masked off; zeros expected there
					merged = (ctrl_img & ~lane_mask)
						| (wr_req.data[REG_W-1:0] & lane_mask);
					merged = merged & CTRL_WR_MASK;
					nxt_st.nmi_edge_polarity =
						edge_pol_t'(merged[NMI_EDGE_POS]);
					for (int k = 0; k < LINES; k++)
						nxt_st.sense[k] = merged[SENSE_POS[k]];
				end
				MASK_OFS:
				begin
					merged = (st_ff.mask & ~lane_mask)
						| (wr_req.data[REG_W-1:0] & lane_mask);
					nxt_st.mask = merged & STAT_MASK;
				end
				default: merged = '0;
			endcase
		end
		// level output, high while any unmasked status bit is set
		nxt_st.irq_out = |(nxt_st.status & nxt_st.mask);
	end

	// single state register; edge, status and mask reset values come from the package
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_ff.nmi_edge_polarity <= edge_pol_t'(CTRL_RESET[NMI_EDGE_POS]);
			st_ff.sense <= '0;
			st_ff.status <= STAT_RESET;
			st_ff.mask <= MASK_RESET;
			st_ff.nmi_req <= 1'h0;
			st_ff.irq_req <= '0;
			st_ff.irq_out <= 1'h0;
		end
		else
			st_ff <= nxt_st;
	end

	assign nmi_req = st_ff.nmi_req;
	assign irq_req = st_ff.irq_req;
	assign irq_out = st_ff.irq_out;

endmodule
`default_nettype wire

// ==== hw/eic_pkg.sv ====
// Purpose: shared constants and types for the external interrupt control block
// Assumes: one 10 MHz clock, AXI4-Lite register access, 16-bit registers
// Notes:   status and mask registers share the control register's bit layout
package eic_pkg;

	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int REG_W = 16;
	localparam int LINES = 6;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] MASK_OFS = 8'h08;

	// field positions; line k of the sense array is lines 0,1,2,3,6,7
	localparam int NMI_LEVEL_POS = 15;
	localparam int NMI_EDGE_POS = 8;
	localparam int NMI_STAT_POS = 8;
	localparam int SENSE_POS [LINES] = '{7, 6, 5, 4, 1, 0};

	// reset values and writable-bit masks
	localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [REG_W-1:0] CTRL_WR_MASK = 16'h01F3;
	localparam logic [REG_W-1:0] STAT_MASK = 16'h01F3;
	localparam logic [REG_W-1:0] STAT_RESET = 16'h0000;
	localparam logic [REG_W-1:0] MASK_RESET = 16'h0000;

	// idle level of the pins, so reset never fakes an edge
	localparam logic PIN_IDLE = 1'h1;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// detection modes
	typedef enum logic {SENSE_LOW_LEVEL, SENSE_FALL_EDGE} sense_t;
	typedef enum logic {EDGE_FALLING, EDGE_RISING} edge_pol_t;

	// one accepted register write
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
	} wr_req_t;

endpackage

// ==== hw/pin_sync.sv ====
// Purpose: two-flop synchroniser with edge detection for one pin
// Assumes: pin may change at any time relative to sys_clk
// Notes:   the meta stage feeds only the sync stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import eic_pkg::*;
#(
	parameter logic IDLE = PIN_IDLE
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// pin and its views
	input wire logic pin,
	output logic level,
	output logic rose,
	output logic fell
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} sync_state_t;

	sync_state_t st_ff;
	sync_state_t nxt_st;

	// shift the pin through; edges compare two settled stages
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.meta = pin;
		nxt_st.sync = st_ff.meta;
		nxt_st.last = st_ff.sync;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_ff <= '{IDLE, IDLE, IDLE};
		else
			st_ff <= nxt_st;
	end

	assign level = st_ff.sync;
	assign rose = st_ff.sync & ~st_ff.last;
	assign fell = ~st_ff.sync & st_ff.last;

endmodule
`default_nettype wire

// ==== hw/axil_port.sv ====
// Purpose: AXI4-Lite slave front end, one write and one read in flight
// Assumes: the owner decodes addresses combinationally
// Notes:   write lands one cycle after bvalid rises; read data two after ar
`timescale 1ns/1ps
`default_nettype none
module axil_port
	import eic_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// write address and data
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [STRB_W-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// owner side
	output wr_req_t wr_req,
	output logic wr_fire,
	input wire logic wr_err,
	output logic [ADDR_W-1:0] rd_addr,
	output logic rd_fire,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic rd_err
);

	typedef struct packed {
		logic aw_have;
		logic w_have;
		logic awready;
		logic wready;
		wr_req_t req;
		logic wr_fire;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_have;
		logic arready;
		logic [ADDR_W-1:0] raddr;
		logic rd_fire;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} port_state_t;

	port_state_t st_ff;
	port_state_t nxt_st;

	// address and data are taken in either order, answered once both held
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.wr_fire = 1'h0;
		nxt_st.rd_fire = 1'h0;
		if (awvalid && st_ff.awready)
		begin
			nxt_st.aw_have = 1'h1;
			nxt_st.req.addr = awaddr;
		end
		if (wvalid && st_ff.wready)
		begin
			nxt_st.w_have = 1'h1;
			nxt_st.req.data = wdata;
			nxt_st.req.strb = wstrb;
		end
		if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid)
		begin
			nxt_st.bvalid = 1'h1;
			nxt_st.wr_fire = !wr_err;
			nxt_st.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (st_ff.bvalid && bready)
		begin
			nxt_st.bvalid = 1'h0;
			nxt_st.aw_have = 1'h0;
			nxt_st.w_have = 1'h0;
		end
		// readies stay low while a write is held, so nothing is dropped
		nxt_st.awready = !nxt_st.aw_have;
		nxt_st.wready = !nxt_st.w_have;
		if (arvalid && st_ff.arready)
		begin
			nxt_st.ar_have = 1'h1;
			nxt_st.raddr = araddr;
			nxt_st.rd_fire = 1'h1;
		end
		if (st_ff.rd_fire)
		begin
			nxt_st.rvalid = 1'h1;
			nxt_st.rdata = rd_data;
			nxt_st.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (st_ff.rvalid && rready)
		begin
			nxt_st.rvalid = 1'h0;
			nxt_st.ar_have = 1'h0;
		end
		nxt_st.arready = !nxt_st.ar_have;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign awready = st_ff.awready;
	assign wready = st_ff.wready;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = st_ff.arready;
	assign rvalid = st_ff.rvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign wr_req = st_ff.req;
	assign wr_fire = st_ff.wr_fire;
	assign rd_addr = st_ff.raddr;
	assign rd_fire = st_ff.rd_fire;

endmodule
`default_nettype wire

// ==== testbench/ext_int_ctrl_properties.sv ====
// Purpose: port properties of the external interrupt control block
// Assumes: pins held several cycles between changes
// Notes:   pin to request lag is three edges
`timescale 1ns/1ps
`default_nettype none
module ext_int_ctrl_properties
	import eic_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// read channel
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	// pins and requests
	input wire logic nmi_pin,
	input wire logic [LINES-1:0] irq_pin_b,
	input wire logic nmi_req,
	input wire logic [LINES-1:0] irq_req,
	input wire logic irq_out
);
	logic ctl_ff;
	logic pin_ff;
	logic [2:0] age_ff;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// read target and how long the nmi pin has stood still
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctl_ff <= 1'h0;
			pin_ff <= 1'h1;
			age_ff <= 3'h0;
		end
		else
		begin
			if (arvalid && arready)
				ctl_ff <= (araddr == CTRL_OFS);
			pin_ff <= nmi_pin;
			if (nmi_pin != pin_ff)
				age_ff <= 3'h0;
			else
				age_ff <= age_ff + {2'h0, age_ff != 3'h7};
		end
	end
	AST_NMI_LEVEL: assert property (
		$rose(rvalid) && ctl_ff && age_ff == 3'h7
		|-> rdata[NMI_LEVEL_POS] == nmi_pin) else $error("level bit wrong");
	AST_CTRL_RSVD: assert property (
		rvalid && ctl_ff |-> rdata[14:9] == 6'h00 && rdata[3:2] == 2'h0)
		else $error("reserved bit set");
	AST_RD_UPPER: assert property (
		rvalid |-> rdata[31:16] == 16'h0000) else $error("upper bits set");
	AST_NMI_CAUSE: assert property (
		nmi_req |-> $past(nmi_pin, 3) != $past(nmi_pin, 4))
		else $error("nmi request without edge");
	AST_NMI_ONCE: assert property (
		nmi_req |=> !nmi_req) else $error("nmi request too long");
	AST_NMI_QUIET: assert property (
		age_ff == 3'h7 |-> !nmi_req) else $error("nmi request on quiet pin");
	AST_IRQ_CAUSE: assert property (
		(irq_req & $past(irq_pin_b, 3)) == '0) else $error("line request, pin high");
	cover property (nmi_req);
	cover property (irq_out);
	cover property (rvalid && rresp == RESP_SLVERR);
endmodule
bind ext_int_ctrl ext_int_ctrl_properties i_ext_int_ctrl_properties (
	.sys_clk, .rst_b, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.nmi_pin, .irq_pin_b, .nmi_req, .irq_req, .irq_out);
`default_nettype wire

// ==== testbench/pin_source.sv ====
// Purpose: far-side model driving the nmi and line pins
// Assumes: pins move right after a clock edge
// Notes:   hold sets how slowly the source moves on
`timescale 1ns/1ps
`default_nettype none
module pin_source
	import eic_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// pins
	output logic nmi_pin,
	output logic [LINES-1:0] irq_pin_b
);
	// idle levels from time zero
	initial
	begin
		nmi_pin = PIN_IDLE;
		irq_pin_b = '1;
	end
	// hold long enough that the synchroniser sees every change
	task automatic drive(input logic n, input logic [LINES-1:0] b, input int h);
		@(posedge sys_clk);
		nmi_pin <= n;
		irq_pin_b <= b;
		repeat (h) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_ext_int_ctrl.sv ====
// Purpose: self-checking bench for the external interrupt control block
// Assumes: 10 MHz clock, pins moved by the pin source model
// Notes:   read answers are queued by the driver, popped by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_ext_int_ctrl
	import eic_pkg::*;
;
	logic sys_clk = 1'h0;
	logic rst_b = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, b;
	logic [1:0] bresp, rresp;
	logic [LINES-1:0] irq_pin_b, irq_req;
	logic nmi_pin, nmi_req, irq_out, awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [33:0] exp_q [$];
	logic [1:0] exp_b [$];
	logic [31:0] seed = 32'h5DEF;
	int failures = 0, num_checks = 0, m, k;
	int nmi_pulses = 0;
	// clock, 100 ns period
	initial forever #50 sys_clk = ~sys_clk;
	ext_int_ctrl i_ext_int_ctrl (.sys_clk, .rst_b, .awaddr, .awprot(3'h0),
		.awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .nmi_pin, .irq_pin_b, .nmi_req, .irq_req,
		.irq_out);
	pin_source i_pin_source (.sys_clk, .nmi_pin, .irq_pin_b);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [33:0] s, input logic [33:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one bus transfer; the wait is bounded so a dead slave ends the run
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [33:0] e);
		int n;
		@(posedge sys_clk);
		if (w)
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			exp_b.push_back(e[33:32]);
		end
		else
		begin
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			exp_q.push_back(e);
		end
		for (n = 0; n < 50; n++)
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
			if (arready)
				arvalid <= 1'h0;
			if (w ? bvalid : rvalid)
				break;
		end
		bready <= 1'h0;
		rready <= 1'h0;
		if (n == 50)
		begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] s = RESP_OKAY);
		bus(1'h0, a, 32'h0, {s, d});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] s = RESP_OKAY);
		bus(1'h1, a, d, {s, 32'h0});
	endtask
	// oldest expectation against each answer; nmi pulses are counted
	always @(posedge sys_clk)
	begin
		if (rvalid === 1'h1 && rready === 1'h1 && exp_q.size() > 0)
			check({rresp, rdata}, exp_q.pop_front());
		if (bvalid === 1'h1 && bready === 1'h1 && exp_b.size() > 0)
			check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
		if (nmi_req === 1'h1)
			nmi_pulses++;
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge sys_clk);
		// reset view, then an unmapped word
		rd(CTRL_OFS, 32'h00008000);
		rd(MASK_OFS, 32'h0);
		rd(8'h0C, 32'h0, RESP_SLVERR);
		wr(8'h0C, 32'h000001F3, RESP_SLVERR);
		// level bit written high; reserved bits stay zero as software must
		wr(CTRL_OFS, 32'hFFFF81F3);
		rd(CTRL_OFS, 32'h000081F3);
		i_pin_source.drive(1'h0, '1, 6);
		rd(CTRL_OFS, 32'h000001F3);
		// random legal settings read back
		repeat (4)
		begin
			b = xs() & {16'h0, CTRL_WR_MASK};
			wr(CTRL_OFS, b);
			rd(CTRL_OFS, b);
		end
		// wrong-way nmi edge ignored, right-way edge latched
		wr(MASK_OFS, 32'h00000100);
		for (m = 0; m < 2; m++)
		begin
			// park the pin first so the wrong-way edge really happens
			i_pin_source.drive(m[0], '1, 6);
			wr(CTRL_OFS, {23'h0, m[0], 8'h00});
			i_pin_source.drive(!m[0], '1, 6);
			rd(STAT_OFS, 32'h0);
			i_pin_source.drive(m[0], '1, 6);
			check({33'h0, irq_out}, 34'h1);
			rd(STAT_OFS, 32'h00000100);
			rd(STAT_OFS, 32'h0);
			check({33'h0, irq_out}, 34'h0);
		end
		// level sense re-raises while low, edge sense raises once
		for (m = 0; m < 2; m++)
		begin
			wr(CTRL_OFS, m ? 32'h000000F3 : 32'h0);
			for (k = 0; k < LINES; k++)
			begin
				b = 32'h1 << SENSE_POS[k];
				i_pin_source.drive(1'h1, ~(6'h01 << k), 6);
				check({33'h0, irq_out}, 34'h0);
				check({28'h0, irq_req}, m ? 34'h0 : (34'h1 << k));
				rd(STAT_OFS, b);
				rd(STAT_OFS, m ? 32'h0 : b);
				i_pin_source.drive(1'h1, '1, 6);
				rd(STAT_OFS, m ? 32'h0 : b);
				rd(STAT_OFS, 32'h0);
			end
		end
		// let the last answer reach the monitor before closing
		repeat (2) @(posedge sys_clk);
		check(34'(nmi_pulses), 34'h2);
		check(34'(exp_q.size() + exp_b.size()), 34'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
